/* File: src/dtc_ctrl.sv */
// Two-channel temperature conversion controller with APB registers and alert output.
//
// How it works
// - Standby pin low stops; high operates.
// - Standby keeps results and thresholds.
// - Address straps captured once after power-up.
// - Alert pin only pulls low.
// - Serial data pin never driven; its enable is tied low.
// - Each result is eight bits.
// - Latch results and compare four thresholds in the same cycle.
// - Each channel integrates 60 ms.
// - Every conversion covers remote and local.
// - Both channels measured even if unused.
// - Start by command or auto timer.
// - Busy flag set during conversion.
// - Reads return previous completed results.
// - Standby during conversion aborts, keeps old values.
// - Results are signed degrees, one per bit.
// - Standby pin blocks one-shot command.
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_ctrl #(
  parameter int unsigned CYC_PER_MS = `DTC_CLK_KHZ,
  parameter logic [4:0]  ADDR_BASE  = 5'h00
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  remote_sample,
  input  wire logic [7:0]  local_sample,
  input  wire logic        low_power_hold_n,
  input  wire logic        slave_id_strap_0,
  input  wire logic        slave_id_strap_1,
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe,
  output logic             alert_pin_o,
  output logic             alert_pin_oe,
  output logic             irq
);
  localparam int unsigned DIV_W = $clog2(CYC_PER_MS + 1);

  logic [4:0] pins_s;
  logic       hold_n_s;
  logic       strap0_s;
  logic       strap1_s;
  logic       sclk_s;
  logic       sda_s;

  dtc_conv_if cv ();

  dtc_sync #(.W(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({low_power_hold_n, slave_id_strap_1, slave_id_strap_0,
               serial_clock_pin, serial_data_pin_i}),
    .q       (pins_s)
  );

  assign {hold_n_s, strap1_s, strap0_s, sclk_s, sda_s} = pins_s;

  logic [DIV_W-1:0] ms_div;
  logic [DIV_W-1:0] next_ms_div;
  logic             ms_tick;

  assign ms_tick = (ms_div == DIV_W'(CYC_PER_MS - 1));

  dtc_adc u_adc (
    .pclk    (pclk),
    .presetn (presetn),
    .ms_tick (ms_tick),
    .cv      (cv)
  );

  dtc_pkg::dtc_conv_state_t state;
  dtc_pkg::dtc_conv_state_t next_state;

  logic [7:0]  remote_temp;
  logic [7:0]  next_remote_temp;
  logic [7:0]  local_temp;
  logic [7:0]  next_local_temp;
  logic [7:0]  remote_hold;
  logic [7:0]  next_remote_hold;
  logic [7:0]  loc_hi;
  logic [7:0]  next_loc_hi;
  logic [7:0]  loc_lo;
  logic [7:0]  next_loc_lo;
  logic [7:0]  rem_hi;
  logic [7:0]  next_rem_hi;
  logic [7:0]  rem_lo;
  logic [7:0]  next_rem_lo;
  logic        run_stop;
  logic        next_run_stop;
  logic [15:0] rate;
  logic [15:0] next_rate;
  logic [15:0] auto_cnt;
  logic [15:0] next_auto_cnt;
  logic [5:0]  irq_st;
  logic [5:0]  next_irq_st;
  logic [5:0]  irq_mask;
  logic [5:0]  next_irq_mask;
  logic [1:0]  strap_wait;
  logic [1:0]  next_strap_wait;
  logic [1:0]  strap;
  logic [1:0]  next_strap;
  logic        sda_prev;
  logic        link_active;
  logic        next_link_active;

  logic wr;
  logic rd;
  logic oneshot_wr;
  logic stop_wr;
  logic auto_fire;
  logic busy;
  logic [5:0] irq_set;
  logic [31:0] next_prdata;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `DTC_OFF_REMOTE, `DTC_OFF_LOCAL, `DTC_OFF_STATUS, `DTC_OFF_CONFIG,
      `DTC_OFF_RATE, `DTC_OFF_ONESHOT, `DTC_OFF_LOC_HI, `DTC_OFF_LOC_LO,
      `DTC_OFF_REM_HI, `DTC_OFF_REM_LO, `DTC_OFF_IRQ_ST, `DTC_OFF_IRQ_MASK,
      `DTC_OFF_ADDR: is_mapped = 1'b1;
      default:       is_mapped = 1'b0;
    endcase
  endfunction

  assign wr         = psel && penable && pwrite && is_mapped(paddr);
  assign rd         = psel && penable && !pwrite && is_mapped(paddr);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !is_mapped(paddr);
  assign oneshot_wr = wr && (paddr == `DTC_OFF_ONESHOT);
  assign stop_wr    = wr && (paddr == `DTC_OFF_CONFIG) && pwdata[`DTC_CFG_RUN_STOP];
  assign busy       = (state != dtc_pkg::conv_idle);

  // Auto timer fires only in operate mode with software run selected; its count advances whenever idle.
  assign auto_fire = !busy && hold_n_s && !run_stop && ms_tick && (auto_cnt >= rate);

  assign cv.sample = (state == dtc_pkg::conv_local) ? local_sample : remote_sample;
  assign cv.abort  = busy && (!hold_n_s || stop_wr);

  // Conversion sequencer: remote first, then local, results latched together.
  always_comb begin
    next_state       = state;
    next_remote_temp = remote_temp;
    next_local_temp  = local_temp;
    next_remote_hold = remote_hold;
    next_auto_cnt    = auto_cnt;
    cv.start         = 1'b0;
    irq_set          = '0;
    if (!busy && ms_tick) begin
      next_auto_cnt = auto_fire ? 16'h0000 : auto_cnt + 16'h0001;
    end
    case (state)
      dtc_pkg::conv_idle: begin
        if ((oneshot_wr || auto_fire) && hold_n_s) begin
          next_state = dtc_pkg::conv_remote;
          cv.start   = 1'b1;
        end
      end
      dtc_pkg::conv_remote: begin
        if (cv.abort) begin
          next_state             = dtc_pkg::conv_idle;
          irq_set[`DTC_IRQ_ABORT] = 1'b1;
        end else if (cv.done) begin
          next_remote_hold = cv.result;
          next_state       = dtc_pkg::conv_local;
          cv.start         = 1'b1;
        end
      end
      dtc_pkg::conv_local: begin
        if (cv.abort) begin
          next_state             = dtc_pkg::conv_idle;
          irq_set[`DTC_IRQ_ABORT] = 1'b1;
        end else if (cv.done) begin
          next_remote_temp = remote_hold;
          next_local_temp  = cv.result;
          next_state       = dtc_pkg::conv_idle;
          next_auto_cnt    = 16'h0000;
          irq_set[`DTC_IRQ_DONE]   = 1'b1;
          irq_set[`DTC_IRQ_REM_HI] = dtc_pkg::dtc_gt(remote_hold, rem_hi);
          irq_set[`DTC_IRQ_REM_LO] = dtc_pkg::dtc_gt(rem_lo, remote_hold);
          irq_set[`DTC_IRQ_LOC_HI] = dtc_pkg::dtc_gt(cv.result, loc_hi);
          irq_set[`DTC_IRQ_LOC_LO] = dtc_pkg::dtc_gt(loc_lo, cv.result);
        end
      end
      default: next_state = dtc_pkg::conv_idle;
    endcase
  end

  // Register writes, read-to-clear status, strap capture and link watch.
  always_comb begin
    next_ms_div      = ms_tick ? '0 : ms_div + DIV_W'(1);
    next_loc_hi      = loc_hi;
    next_loc_lo      = loc_lo;
    next_rem_hi      = rem_hi;
    next_rem_lo      = rem_lo;
    next_run_stop    = run_stop;
    next_rate        = rate;
    next_irq_mask    = irq_mask;
    next_irq_st      = irq_st;
    next_strap_wait  = strap_wait;
    next_strap       = strap;
    next_link_active = link_active;
    if (wr) begin
      case (paddr)
        `DTC_OFF_CONFIG:   next_run_stop = pwdata[`DTC_CFG_RUN_STOP];
        `DTC_OFF_RATE:     next_rate     = pwdata[15:0];
        `DTC_OFF_LOC_HI:   next_loc_hi   = pwdata[7:0];
        `DTC_OFF_LOC_LO:   next_loc_lo   = pwdata[7:0];
        `DTC_OFF_REM_HI:   next_rem_hi   = pwdata[7:0];
        `DTC_OFF_REM_LO:   next_rem_lo   = pwdata[7:0];
        `DTC_OFF_IRQ_MASK: next_irq_mask = pwdata[5:0];
        default:           next_irq_mask = irq_mask;
      endcase
    end
    // Only the bits that the read showed are cleared, so a later event survives.
    if (rd && (paddr == `DTC_OFF_IRQ_ST)) begin
      next_irq_st = irq_st & ~prdata[5:0];
    end
    next_irq_st = next_irq_st | irq_set;
    // Straps settle through the synchroniser before the single capture.
    if (strap_wait != 2'd3) begin
      next_strap_wait = strap_wait + 2'd1;
      if (strap_wait == 2'd2) begin
        next_strap = {strap1_s, strap0_s};
      end
    end
    if (sclk_s && sda_prev && !sda_s) begin
      next_link_active = 1'b1;
    end else if (sclk_s && !sda_prev && sda_s) begin
      next_link_active = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= dtc_pkg::conv_idle;
      remote_temp <= 8'h00;
      local_temp  <= 8'h00;
      remote_hold <= 8'h00;
      loc_hi      <= `DTC_HI_RST;
      loc_lo      <= `DTC_LO_RST;
      rem_hi      <= `DTC_HI_RST;
      rem_lo      <= `DTC_LO_RST;
      run_stop    <= 1'b0;
      rate        <= `DTC_RATE_RST;
      auto_cnt    <= 16'h0000;
      irq_st      <= 6'h00;
      irq_mask    <= 6'h00;
      strap_wait  <= 2'd0;
      strap       <= 2'd0;
      sda_prev    <= 1'b1;
      link_active <= 1'b0;
      ms_div      <= '0;
      prdata      <= 32'h0000_0000;
    end else begin
      state       <= next_state;
      remote_temp <= next_remote_temp;
      local_temp  <= next_local_temp;
      remote_hold <= next_remote_hold;
      loc_hi      <= next_loc_hi;
      loc_lo      <= next_loc_lo;
      rem_hi      <= next_rem_hi;
      rem_lo      <= next_rem_lo;
      run_stop    <= next_run_stop;
      rate        <= next_rate;
      auto_cnt    <= next_auto_cnt;
      irq_st      <= next_irq_st;
      irq_mask    <= next_irq_mask;
      strap_wait  <= next_strap_wait;
      strap       <= next_strap;
      sda_prev    <= sda_s;
      link_active <= next_link_active;
      ms_div      <= next_ms_div;
      prdata      <= next_prdata;
    end
  end

  // Read data is captured in the setup cycle, so the access phase shows a flip-flop.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `DTC_OFF_REMOTE:   next_prdata = {24'h000000, remote_temp};
        `DTC_OFF_LOCAL:    next_prdata = {24'h000000, local_temp};
        `DTC_OFF_STATUS:   next_prdata = {29'h0, !hold_n_s || run_stop, link_active, busy};
        `DTC_OFF_CONFIG:   next_prdata = {31'h0, run_stop};
        `DTC_OFF_RATE:     next_prdata = {16'h0000, rate};
        `DTC_OFF_LOC_HI:   next_prdata = {24'h000000, loc_hi};
        `DTC_OFF_LOC_LO:   next_prdata = {24'h000000, loc_lo};
        `DTC_OFF_REM_HI:   next_prdata = {24'h000000, rem_hi};
        `DTC_OFF_REM_LO:   next_prdata = {24'h000000, rem_lo};
        `DTC_OFF_IRQ_ST:   next_prdata = {26'h0, irq_st};
        `DTC_OFF_IRQ_MASK: next_prdata = {26'h0, irq_mask};
        `DTC_OFF_ADDR:     next_prdata = {25'h0, ADDR_BASE, strap};
        default:           next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Pins only ever pull low; byte framing on the serial bus sits outside this block.
  assign irq                = |(irq_st & irq_mask);
  assign alert_pin_o        = 1'b0;
  assign alert_pin_oe       = irq;
  assign serial_data_pin_o  = 1'b0;
  assign serial_data_pin_oe = 1'b0;
endmodule

/* File: src/dtc_defines.svh */
// Offsets, field positions, reset values and timing counts of the conversion controller.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_CLK_KHZ      40000
`define DTC_INTEG_MS     60
`define DTC_OFF_REMOTE   8'h00
`define DTC_OFF_LOCAL    8'h04
`define DTC_OFF_STATUS   8'h08
`define DTC_OFF_CONFIG   8'h0c
`define DTC_OFF_RATE     8'h10
`define DTC_OFF_ONESHOT  8'h14
`define DTC_OFF_LOC_HI   8'h18
`define DTC_OFF_LOC_LO   8'h1c
`define DTC_OFF_REM_HI   8'h20
`define DTC_OFF_REM_LO   8'h24
`define DTC_OFF_IRQ_ST   8'h28
`define DTC_OFF_IRQ_MASK 8'h2c
`define DTC_OFF_ADDR     8'h30
`define DTC_CFG_RUN_STOP 0
`define DTC_ST_BUSY      0
`define DTC_ST_LINK      1
`define DTC_ST_STANDBY   2
`define DTC_IRQ_DONE     0
`define DTC_IRQ_REM_HI   1
`define DTC_IRQ_REM_LO   2
`define DTC_IRQ_LOC_HI   3
`define DTC_IRQ_LOC_LO   4
`define DTC_IRQ_ABORT    5
`define DTC_HI_RST       8'h7f
`define DTC_LO_RST       8'hc9
`define DTC_RATE_RST     16'h03e8
`endif

/* File: src/dtc_pkg.sv */
// Types and shared arithmetic of the conversion controller.
package dtc_pkg;
  typedef enum logic [1:0] {conv_idle, conv_remote, conv_local} dtc_conv_state_t;

  // Signed compare of two's-complement temperatures.
  function automatic logic dtc_gt(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) > $signed(b);
  endfunction
endpackage

/* File: src/dtc_conv_if.sv */
// Handshake between the sequencer and the integrating converter.
`timescale 1ns/1ps
interface dtc_conv_if;
  logic       start;
  logic       abort;
  logic       done;
  logic [7:0] sample;
  logic [7:0] result;
  modport ctrl (output start, output abort, output sample, input done, input result);
  modport adc  (input start, input abort, input sample, output done, output result);
endinterface

/* File: src/dtc_sync.sv */
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module dtc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: src/dtc_adc.sv */
// Integrating converter timing: one channel per start, result after the integration period.
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_adc (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ms_tick,
  dtc_conv_if.adc   cv
);
  localparam logic [6:0] INTEG_TICKS = 7'(`DTC_INTEG_MS);

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       run;
  logic       next_run;
  logic       done_q;
  logic       next_done;
  logic [7:0] res;
  logic [7:0] next_res;

  assign cv.done   = done_q;
  assign cv.result = res;

  // The millisecond tick is shared, so the first tick of a channel may come early by under 1 ms.
  always_comb begin
    next_cnt  = cnt;
    next_run  = run;
    next_done = 1'b0;
    next_res  = res;
    if (cv.abort) begin
      next_run = 1'b0;
      next_cnt = '0;
    end else if (cv.start) begin
      next_run = 1'b1;
      next_cnt = '0;
    end else if (run && ms_tick) begin
      if (cnt == INTEG_TICKS - 7'd1) begin
        next_run  = 1'b0;
        next_done = 1'b1;
        next_res  = cv.sample;
      end else begin
        next_cnt = cnt + 7'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= '0;
      run    <= 1'b0;
      done_q <= 1'b0;
      res    <= '0;
    end else begin
      cnt    <= next_cnt;
      run    <= next_run;
      done_q <= next_done;
      res    <= next_res;
    end
  end
endmodule

/* File: testbench/dtc_host_model.sv */
// Bus host and front-end model facing the conversion controller.
`timescale 1ns/1ps
module dtc_host_model (
  input  wire logic       pclk,
  output logic            scl,
  output logic            sda_low,
  output logic      [7:0] remote_t,
  output logic      [7:0] local_t
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    remote_t = 8'h00;
    local_t = 8'h00;
  end
  task automatic set_temps(input logic [7:0] r, input logic [7:0] l);
    @(posedge pclk);
    remote_t <= r;
    local_t <= l;
  endtask
  // The host alone makes the serial clock; it stands high outside frames.
  // Four system clocks per half period give the 200 ns link clock period.
  task automatic start_frame();
    @(posedge pclk);
    sda_low <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      scl <= 1'b0;
      repeat (4) @(posedge pclk);
      scl <= 1'b1;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic stop_frame();
    @(posedge pclk);
    scl <= 1'b0;
    repeat (4) @(posedge pclk);
    scl <= 1'b1;
    repeat (4) @(posedge pclk);
    sda_low <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

/* File: testbench/dtc_ctrl_chk.sv */
// Port-level assertions of the conversion controller.
`timescale 1ns/1ps
module dtc_ctrl_chk #(
  parameter logic [4:0] ADDR_BASE = 5'h00
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        low_power_hold_n,
  input wire logic        serial_data_pin_o,
  input wire logic        serial_data_pin_oe,
  input wire logic        alert_pin_o,
  input wire logic        alert_pin_oe,
  input wire logic        irq
);
  logic       acc;
  logic [2:0] low_power_hold_n_cnt;
  logic [2:0] next_low_power_hold_n_cnt;
  assign acc = psel && penable;
  // Counts standby cycles so the pin synchroniser and any abort have settled.
  always_comb begin
    next_low_power_hold_n_cnt = low_power_hold_n_cnt;
    if (low_power_hold_n) begin
      next_low_power_hold_n_cnt = 3'h0;
    end else if (low_power_hold_n_cnt != 3'h7) begin
      next_low_power_hold_n_cnt = low_power_hold_n_cnt + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_hold_n_cnt <= 3'h0;
    end else begin
      low_power_hold_n_cnt <= next_low_power_hold_n_cnt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_alert_od; alert_pin_oe |-> !alert_pin_o; endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert driven high");
  property p_alert_irq; alert_pin_oe == irq; endproperty
  a_alert_irq: assert property (p_alert_irq) else $error("alert differs from irq");
  property p_data_od; serial_data_pin_oe |-> !serial_data_pin_o; endproperty
  a_data_od: assert property (p_data_od) else $error("data driven high");
  property p_idle_rd; !acc |-> prdata == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside access");
  property p_temp_8b;
    acc && !pwrite && (paddr == 8'h00 || paddr == 8'h04) |-> prdata[31:8] == 24'h0 && !pslverr;
  endproperty
  a_temp_8b: assert property (p_temp_8b) else $error("result wider than a byte");
  property p_addr_reg;
    acc && !pwrite && paddr == 8'h30 |-> prdata[6:2] == ADDR_BASE && prdata[31:7] == 25'h0;
  endproperty
  a_addr_reg: assert property (p_addr_reg) else $error("bus address wrong");
  property p_clear_low_power_hold_n;
    acc && !pwrite && paddr == 8'h28 && low_power_hold_n_cnt == 3'h7 |=> !irq [*2];
  endproperty
  a_clear_low_power_hold_n: assert property (p_clear_low_power_hold_n) else $error("event in standby");
  property p_low_power_hold_n_quiet; low_power_hold_n_cnt == 3'h7 && !irq && !(acc && pwrite) |=> !irq; endproperty
  a_low_power_hold_n_quiet: assert property (p_low_power_hold_n_quiet) else $error("irq rose in standby");
  c_irq_read: cover property (acc && !pwrite && paddr == 8'h28 && irq);
  c_low_power_hold_n: cover property ($fell(low_power_hold_n));
  c_alert: cover property (alert_pin_oe);
endmodule

/* File: testbench/tb.sv */
// Register-level testbench of the conversion controller.
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  remote_t;
  logic [7:0]  local_t;
  logic        low_power_hold_n = 1'b1;
  logic        strap0 = 1'b1;
  logic        strap1 = 1'b0;
  logic        scl;
  logic        sda_low;
  logic        sdo;
  logic        sdo_oe;
  logic        alert_o;
  logic        alert_oe;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  time         t0;
  int          error_cnt = 0;
  int          checks = 0;
  logic [7:0]  ra [7] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h10, 8'h00, 8'h30};
  logic [31:0] re [7] = '{32'h7f, 32'hc9, 32'h7f, 32'hc9, 32'h3e8, 32'h0, 32'h55};
  wire         sda = !(sdo_oe && !sdo) && !sda_low;
  always #12.5 pclk = ~pclk;
  dtc_ctrl #(.CYC_PER_MS(10), .ADDR_BASE(5'h15)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_sample(remote_t), .local_sample(local_t), .low_power_hold_n(low_power_hold_n),
    .slave_id_strap_0(strap0), .slave_id_strap_1(strap1), .serial_clock_pin(scl),
    .serial_data_pin_i(sda), .serial_data_pin_o(sdo), .serial_data_pin_oe(sdo_oe),
    .alert_pin_o(alert_o), .alert_pin_oe(alert_oe), .irq(irq));
  dtc_host_model host (.pclk(pclk), .scl(scl), .sda_low(sda_low), .remote_t(remote_t),
    .local_t(local_t));
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: bit %b want %b", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk32(rd, e);
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== v && n < 2000);
    chk1(rd[0], v);
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 7; i++) rdc(ra[i], re[i]);
    strap0 <= 1'b0;
    strap1 <= 1'b1;
    apb(1'b0, 8'h34, 32'h0);
    chk1(err, 1'b1);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b1, 8'h2c, 32'h3f);
    rdc(8'h30, 32'h55);
    host.start_frame();
    apb(1'b0, 8'h08, 32'h0);
    chk1(rd[1], 1'b1);
    host.stop_frame();
    apb(1'b0, 8'h08, 32'h0);
    chk1(rd[1], 1'b0);
    host.set_temps(8'h85, 8'h19);
    apb(1'b1, 8'h14, 32'h0);
    t0 = $time;
    rdc(8'h08, 32'h5);
    rdc(8'h00, 32'h0);
    wait_busy(1'b0);
    // Two channels of 60 ms at 10 cycles per ms, plus tick phase and polling slack.
    chk1(($time - t0) >= 29500 && ($time - t0) <= 30375, 1'b1);
    rdc(8'h00, 32'h85);
    rdc(8'h04, 32'h19);
    chk1(irq, 1'b1);
    rdc(8'h28, 32'h05);
    @(posedge pclk);
    chk1(irq, 1'b0);
    host.set_temps(8'h3c, 8'h20);
    apb(1'b1, 8'h14, 32'h0);
    repeat (200) @(posedge pclk);
    low_power_hold_n <= 1'b0;
    wait_busy(1'b0);
    rdc(8'h00, 32'h85);
    rdc(8'h28, 32'h20);
    rdc(8'h20, 32'h7f);
    apb(1'b1, 8'h14, 32'h0);
    repeat (10) @(posedge pclk);
    rdc(8'h08, 32'h4);
    rdc(8'h28, 32'h0);
    low_power_hold_n <= 1'b1;
    apb(1'b1, 8'h18, 32'h10);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h0c, 32'h0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdc(8'h00, 32'h3c);
    rdc(8'h04, 32'h20);
    rdc(8'h28, 32'h09);
    host.set_temps(8'h01, 8'h02);
    wait_busy(1'b1);
    apb(1'b1, 8'h0c, 32'h1);
    rdc(8'h08, 32'h4);
    rdc(8'h00, 32'h3c);
    rdc(8'h04, 32'h20);
    rdc(8'h28, 32'h20);
    end_sim();
  end
endmodule
bind dtc_ctrl dtc_ctrl_chk #(.ADDR_BASE(ADDR_BASE)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .low_power_hold_n(low_power_hold_n),
  .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe(serial_data_pin_oe),
  .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe), .irq(irq));
